// [mcc_crc32.v]
// CRC32 checker with programmable polynomial and input mirroring
`timescale 1ns/1ns
`include "mcc_regs.vh"
module mcc_crc32 (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        init,
  input  wire [31:0] poly,
  input  wire        bit_mirror,
  input  wire        byte_mirror,
  input  wire        in_valid,
  input  wire [31:0] in_data,
  output reg  [31:0] crc
);

  // ------------------------------------------------------------------
  // Mirroring and one word of CRC
  // ------------------------------------------------------------------
  function [31:0] mirror;
    input [31:0] d;
    input        bm;
    input        ym;
    reg   [31:0] t;
    integer      i;
    begin
      t = ym ? {d[7:0], d[15:8], d[23:16], d[31:24]} : d;
      mirror = t;
      if (bm) begin
        for (i = 0; i < 32; i = i + 1) begin
          mirror[i] = t[(i & 24) + 7 - (i & 7)];
        end
      end
    end
  endfunction

  function [31:0] crc_word;
    input [31:0] c;
    input [31:0] d;
    input [31:0] p;
    reg   [31:0] r;
    integer      i;
    begin
      r = c;
      for (i = 31; i >= 0; i = i - 1) begin
        r = (r[31] ^ d[i]) ? ({r[30:0], 1'b0} ^ p) : {r[30:0], 1'b0};
      end
      crc_word = r;
    end
  endfunction

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      crc <= `MCC_CRC_INIT;
    end else if (init) begin
      crc <= `MCC_CRC_INIT;
    end else if (in_valid) begin
      crc <= crc_word(crc, mirror(in_data, bit_mirror, byte_mirror), poly);
    end
  end

endmodule

// [mcc_dma.v]
// Memory-copy DMA channel with AHB-Lite registers and CRC checker for chsel 0 to 3
//
// Implementation choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ns
`include "mcc_regs.vh"
module mcc_dma (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  output reg         mem_req,
  output reg         mem_write,
  output reg  [31:0] mem_addr,
  output reg  [31:0] mem_wdata,
  input  wire [31:0] mem_rdata,
  input  wire        mem_ack,
  output wire        irq,
  output reg         crc_fault
);

  localparam S_IDLE  = 3'h0;
  localparam S_FETCH = 3'h1;
  localparam S_LOAD  = 3'h2;
  localparam S_RD    = 3'h3;
  localparam S_WR    = 3'h4;
  localparam S_STEP  = 3'h5;
  localparam S_END   = 3'h6;

  localparam F_LINK = 3'h0;
  localparam F_SRC  = 3'h1;
  localparam F_DST  = 3'h2;
  localparam F_XCNT = 3'h3;
  localparam F_XMOD = 3'h4;
  localparam F_YCNT = 3'h5;
  localparam F_YMOD = 3'h6;
  localparam F_CFG  = 3'h7;

  // Programmed registers
  reg  [15:0] ctrl;
  reg  [31:0] src_addr;
  reg  [31:0] dst_addr;
  reg  [15:0] xcnt;
  reg  [31:0] xmod;
  reg  [15:0] ycnt;
  reg  [31:0] ymod;
  reg  [31:0] dptr;
  reg  [31:0] poly;
  reg  [31:0] crc_exp;
  reg  [31:0] fill;
  reg  [3:0]  stat;
  reg  [3:0]  mask;
  reg  [2:0]  chsel;
  // Working copies
  reg  [15:0] wcfg;
  reg  [31:0] wsrc;
  reg  [31:0] wdst;
  reg  [15:0] wxcnt;
  reg  [31:0] wxmod;
  reg  [15:0] wycnt;
  reg  [31:0] wymod;
  reg  [31:0] link;
  reg  [31:0] cur_src;
  reg  [31:0] cur_dst;
  reg  [15:0] xi;
  reg  [15:0] yi;
  reg  [31:0] ecnt;
  reg  [31:0] data_q;
  reg  [2:0]  fidx;
  reg  [2:0]  state;
  reg         start_req;
  reg         crc_init;
  // Bus pipeline
  reg         rd_ph;
  reg         rd_ok;
  reg         wr_ph;
  reg  [7:0]  rd_addr;
  reg  [7:0]  wr_addr;
  reg  [31:0] next_hrdata;

  wire [31:0] crc;
  wire        aph = hsel & htrans[1] & hready;
  wire        bus_wr = wr_ph;
  wire [1:0]  crcm = (chsel < `MCC_CRC_CHANS) ? wcfg[`MCC_CRCM] : `MCC_CRC_OFF;
  wire        crc_on = (crcm == `MCC_CRC_SCAN) | (crcm == `MCC_CRC_XFER);
  wire        fill_on = (crcm == `MCC_CRC_FILL);
  wire        twod = wcfg[`MCC_TWOD];
  wire [1:0]  kind = wcfg[`MCC_KIND];
  wire [31:0] total = {16'h0000, wxcnt} * {16'h0000, (twod ? wycnt : 16'h0001)};
  wire        last_x = (xi == wxcnt - 16'h0001);
  wire        last_y = !twod | (yi == wycnt - 16'h0001);
  wire        busy = (state != S_IDLE);

  assign hreadyout = !(rd_ph & !rd_ok);
  assign hresp     = 1'b0;
  assign irq       = |(stat & mask);

  // ------------------------------------------------------------------
  // Descriptor layouts
  // ------------------------------------------------------------------
  function [2:0] desc_words;
    input [1:0] k;
    begin
      case (k)
        `MCC_KIND_RING: desc_words = 3'h1;
        `MCC_KIND_L4:   desc_words = 3'h3;
        `MCC_KIND_ARR:  desc_words = 3'h0;
        default:        desc_words = 3'h7;
      endcase
    end
  endfunction

  function [2:0] desc_field;
    input [1:0] k;
    input [2:0] i;
    begin
      case (k)
        `MCC_KIND_RING: desc_field = (i == 3'h0) ? F_LINK : F_SRC;
        `MCC_KIND_L4: begin
          case (i)
            3'h0:    desc_field = F_LINK;
            3'h1:    desc_field = F_SRC;
            3'h2:    desc_field = F_XCNT;
            default: desc_field = F_CFG;
          endcase
        end
        `MCC_KIND_ARR:  desc_field = F_SRC;
        default:        desc_field = i;
      endcase
    end
  endfunction

  // ------------------------------------------------------------------
  // CRC checker
  // ------------------------------------------------------------------
  mcc_crc32 u_crc (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .init        (crc_init),
    .poly        (poly),
    .bit_mirror  (wcfg[`MCC_BITMIR]),
    .byte_mirror (wcfg[`MCC_BYTEMIR]),
    .in_valid    (state == S_RD && mem_req && mem_ack && crc_on),
    .in_data     (mem_rdata),
    .crc         (crc)
  );

  // ------------------------------------------------------------------
  // Register read mux
  // ------------------------------------------------------------------
  always @* begin
    case (rd_addr)
      `MCC_CTRL:  next_hrdata = {16'h0000, ctrl};
      `MCC_SRC:   next_hrdata = src_addr;
      `MCC_DST:   next_hrdata = dst_addr;
      `MCC_XCNT:  next_hrdata = {16'h0000, xcnt};
      `MCC_XMOD:  next_hrdata = xmod;
      `MCC_YCNT:  next_hrdata = {16'h0000, ycnt};
      `MCC_YMOD:  next_hrdata = ymod;
      `MCC_DPTR:  next_hrdata = dptr;
      `MCC_POLY:  next_hrdata = poly;
      `MCC_CEXP:  next_hrdata = crc_exp;
      `MCC_CRES:  next_hrdata = crc;
      `MCC_FILL:  next_hrdata = fill;
      `MCC_STAT:  next_hrdata = {27'h0000000, busy, stat};
      `MCC_MASK:  next_hrdata = {28'h0000000, mask};
      `MCC_CUR:   next_hrdata = cur_src;
      `MCC_CHSEL: next_hrdata = {29'h00000000, chsel};
      default:    next_hrdata = 32'h00000000;
    endcase
  end

  // ------------------------------------------------------------------
  // AHB-Lite slave pipeline
  // ------------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_ph   <= 1'b0;
      rd_ok   <= 1'b0;
      wr_ph   <= 1'b0;
      rd_addr <= 8'h00;
      wr_addr <= 8'h00;
      hrdata  <= 32'h00000000;
    end else begin
      if (rd_ph & !rd_ok) begin
        hrdata <= next_hrdata;
        rd_ok  <= 1'b1;
      end
      if (aph) begin
        rd_ph   <= !hwrite;
        wr_ph   <= hwrite;
        rd_ok   <= 1'b0;
        rd_addr <= {haddr[7:2], 2'b00};
        wr_addr <= {haddr[7:2], 2'b00};
      end else if (hreadyout) begin
        rd_ph <= 1'b0;
        wr_ph <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // Registers and channel engine
  // ------------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl      <= 16'h0000;
      src_addr  <= 32'h00000000;
      dst_addr  <= 32'h00000000;
      xcnt      <= 16'h0000;
      xmod      <= 32'h00000000;
      ycnt      <= 16'h0000;
      ymod      <= 32'h00000000;
      dptr      <= 32'h00000000;
      poly      <= `MCC_POLY_RST;
      crc_exp   <= 32'h00000000;
      fill      <= 32'h00000000;
      stat      <= 4'h0;
      mask      <= 4'h0;
      chsel     <= 3'h0;
      wcfg      <= 16'h0000;
      wsrc      <= 32'h00000000;
      wdst      <= 32'h00000000;
      wxcnt     <= 16'h0000;
      wxmod     <= 32'h00000000;
      wycnt     <= 16'h0000;
      wymod     <= 32'h00000000;
      link      <= 32'h00000000;
      cur_src   <= 32'h00000000;
      cur_dst   <= 32'h00000000;
      xi        <= 16'h0000;
      yi        <= 16'h0000;
      ecnt      <= 32'h00000000;
      data_q    <= 32'h00000000;
      fidx      <= 3'h0;
      state     <= S_IDLE;
      start_req <= 1'b0;
      crc_init  <= 1'b0;
      crc_fault <= 1'b0;
      mem_req   <= 1'b0;
      mem_write <= 1'b0;
      mem_addr  <= 32'h00000000;
      mem_wdata <= 32'h00000000;
    end else begin
      crc_init  <= 1'b0;
      crc_fault <= 1'b0;
      if (bus_wr) begin
        case (wr_addr)
          `MCC_CTRL: begin
            ctrl      <= hwdata[15:0];
            start_req <= hwdata[`MCC_EN];
          end
          `MCC_SRC:   src_addr <= hwdata;
          `MCC_DST:   dst_addr <= hwdata;
          `MCC_XCNT:  xcnt <= hwdata[15:0];
          `MCC_XMOD:  xmod <= hwdata;
          `MCC_YCNT:  ycnt <= hwdata[15:0];
          `MCC_YMOD:  ymod <= hwdata;
          `MCC_DPTR:  dptr <= hwdata;
          `MCC_POLY:  poly <= hwdata;
          `MCC_CEXP:  crc_exp <= hwdata;
          `MCC_FILL:  fill <= hwdata;
          `MCC_STAT:  stat <= stat & ~hwdata[3:0];
          `MCC_MASK:  mask <= hwdata[3:0];
          `MCC_CHSEL: chsel <= hwdata[2:0];
          default: ;
        endcase
      end
      // Abort only between memory handshakes
      if (busy && !ctrl[`MCC_EN] && !mem_req) begin
        state <= S_IDLE;
      end else begin
        case (state)
          S_IDLE: begin
            if (start_req && ctrl[`MCC_EN]) begin
              start_req <= 1'b0;
              wcfg  <= ctrl;
              wsrc  <= src_addr;
              wdst  <= dst_addr;
              wxcnt <= xcnt;
              wxmod <= xmod;
              wycnt <= ycnt;
              wymod <= ymod;
              fidx  <= 3'h0;
              state <= (ctrl[`MCC_FLOW] == `MCC_FLOW_DESC) ? S_FETCH : S_LOAD;
            end
          end
          S_FETCH: begin
            if (!mem_req) begin
              mem_req   <= 1'b1;
              mem_write <= 1'b0;
              mem_addr  <= dptr + {27'h0000000, fidx, 2'b00};
            end else if (mem_ack) begin
              mem_req <= 1'b0;
              case (desc_field(kind, fidx))
                F_LINK: link  <= mem_rdata;
                F_SRC:  wsrc  <= mem_rdata;
                F_DST:  wdst  <= mem_rdata;
                F_XCNT: wxcnt <= mem_rdata[15:0];
                F_XMOD: wxmod <= mem_rdata;
                F_YCNT: wycnt <= mem_rdata[15:0];
                F_YMOD: wymod <= mem_rdata;
                default: wcfg <= mem_rdata[15:0];
              endcase
              if (fidx == desc_words(kind)) begin
                dptr  <= (kind == `MCC_KIND_ARR) ? dptr + 32'h00000004 : link;
                state <= S_LOAD;
              end else begin
                fidx <= fidx + 3'h1;
              end
            end
          end
          S_LOAD: begin
            cur_src  <= wsrc;
            cur_dst  <= wdst;
            xi       <= 16'h0000;
            yi       <= 16'h0000;
            ecnt     <= 32'h00000000;
            crc_init <= 1'b1;
            state    <= fill_on ? S_WR : S_RD;
          end
          S_RD: begin
            if (!mem_req) begin
              mem_req   <= 1'b1;
              mem_write <= 1'b0;
              mem_addr  <= cur_src;
            end else if (mem_ack) begin
              mem_req <= 1'b0;
              data_q  <= mem_rdata;
              state   <= (crcm == `MCC_CRC_SCAN) ? S_STEP : S_WR;
            end
          end
          S_WR: begin
            if (!mem_req) begin
              mem_req   <= 1'b1;
              mem_write <= 1'b1;
              mem_addr  <= cur_dst;
              mem_wdata <= fill_on ? fill : data_q;
            end else if (mem_ack) begin
              mem_req   <= 1'b0;
              mem_write <= 1'b0;
              state     <= S_STEP;
            end
          end
          S_STEP: begin
            ecnt <= ecnt + 32'h00000001;
            if (ecnt + 32'h00000001 == {1'b0, total[31:1]}) begin
              stat[`MCC_ST_HALF] <= 1'b1;
            end
            if (last_x && last_y) begin
              state <= S_END;
            end else begin
              if (last_x) begin
                xi      <= 16'h0000;
                yi      <= yi + 16'h0001;
                cur_src <= cur_src + wymod;
                cur_dst <= cur_dst + wymod;
              end else begin
                xi      <= xi + 16'h0001;
                cur_src <= cur_src + wxmod;
                cur_dst <= cur_dst + wxmod;
              end
              state <= fill_on ? S_WR : S_RD;
            end
          end
          S_END: begin
            if (crc_on && crc != crc_exp) begin
              stat[`MCC_ST_CRCERR] <= 1'b1;
              crc_fault            <= 1'b1;
            end
            case (wcfg[`MCC_FLOW])
              `MCC_FLOW_AUTO: begin
                stat[`MCC_ST_WRAP] <= 1'b1;
                wcfg  <= ctrl;
                wsrc  <= src_addr;
                wdst  <= dst_addr;
                wxcnt <= xcnt;
                wxmod <= xmod;
                wycnt <= ycnt;
                wymod <= ymod;
                state <= S_LOAD;
              end
              `MCC_FLOW_DESC: begin
                stat[`MCC_ST_DONE] <= 1'b1;
                fidx  <= 3'h0;
                state <= S_FETCH;
              end
              default: begin
                stat[`MCC_ST_DONE] <= 1'b1;
                ctrl[`MCC_EN]      <= 1'b0;
                state              <= S_IDLE;
              end
            endcase
          end
          default: state <= S_IDLE;
        endcase
      end
    end
  end

endmodule

// [mcc_dma_props.sv]
// Bus and memory-port checks for the memory-copy DMA engine
`timescale 1ns/1ns
module mcc_dma_props (
  input wire        hclk,
  input wire        hresetn,
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hready,
  input wire [31:0] hrdata,
  input wire        hreadyout,
  input wire        hresp,
  input wire        mem_req,
  input wire        mem_write,
  input wire [31:0] mem_addr,
  input wire [31:0] mem_wdata,
  input wire        mem_ack,
  input wire        crc_fault
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // ----------------------------------------------------------------
  // Bus steps
  // ----------------------------------------------------------------
  sequence s_wr_take;
    hsel && htrans[1] && hready && hwrite;
  endsequence
  sequence s_rd_take;
    hsel && htrans[1] && hready && !hwrite;
  endsequence
  sequence s_rd_hole;
    hsel && htrans[1] && hready && !hwrite && (haddr[7:2] >= 6'h10);
  endsequence
  sequence s_rd_wait;
    !hreadyout ##1 hreadyout;
  endsequence

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("hresp not okay");
  a_wr_zero_wait: assert property (s_wr_take |=> hreadyout)
    else $error("write data phase stalled");
  a_rd_one_wait: assert property (s_rd_take |=> s_rd_wait)
    else $error("read wait not exactly one cycle");
  a_wait_once: assert property (!hreadyout |=> hreadyout)
    else $error("wait state longer than one cycle");
  a_hole_reads_zero: assert property (s_rd_hole |=> ##1 hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property (hreadyout |=> $stable(hrdata))
    else $error("read data changed outside a read");
  a_req_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr)
    && $stable(mem_write) && $stable(mem_wdata))
    else $error("memory request changed before answer");
  a_req_drop: assert property (mem_req && mem_ack |=> !mem_req)
    else $error("memory request not dropped after answer");
  a_fault_pulse: assert property (crc_fault |=> !crc_fault)
    else $error("fault event longer than one cycle");
endmodule

bind mcc_dma mcc_dma_props u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .mem_req(mem_req), .mem_write(mem_write),
  .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .crc_fault(crc_fault));

// [mcc_dma_tb.sv]
// Self-checking bench for the memory-copy DMA engine
`timescale 1ns/1ns
`include "mcc_regs.vh"
module mcc_dma_tb;
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e;} mcc_row_t;
  logic        hclk, hresetn, hsel, hwrite;
  logic [1:0]  htrans;
  logic [3:0]  lat;
  logic [31:0] haddr, hwdata, rd_q, c;
  wire  [31:0] hrdata, mem_addr, mem_wdata, mem_rdata;
  wire         hreadyout, hresp, mem_req, mem_write, mem_ack, irq, crc_fault;
  int          error_cnt, comparisons, cyc, faults, w0;
  mcc_row_t rows [8] = '{'{0, `MCC_POLY, 0, `MCC_POLY_RST}, '{0, `MCC_CRES, 0, 32'hffffffff},
    '{0, `MCC_CTRL, 0, 0}, '{1, `MCC_SRC, 32'h12345678, 32'h12345678},
    '{1, `MCC_XMOD, 32'hfffffffc, 32'hfffffffc}, '{1, 8'h40, 32'ha5a5a5a5, 0},
    '{1, `MCC_CUR, 32'h0000dead, 0}, '{1, `MCC_MASK, 32'hf, 32'hf}};

  mcc_dma dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .mem_req(mem_req),
    .mem_write(mem_write), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack), .irq(irq), .crc_fault(crc_fault));
  mcc_mem_model mem_u (.hclk(hclk), .hresetn(hresetn), .lat(lat), .mem_req(mem_req),
    .mem_write(mem_write), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack));

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc++;
    if (crc_fault === 1'b1) faults++;
    if (cyc == 60000) begin
      error_cnt++;
      print_verdict;
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task chkb(input string n, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %b seen %b", n, e, g);
    end
  endtask
  task rdy;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd_q = hrdata;
  endtask
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    rdy;
    htrans <= 2'b00;
    hwdata <= d;
    rdy;
  endtask
  task poll(input int b, input logic v);
    int k;
    k = 0;
    do begin
      ahb(0, `MCC_STAT, 0);
      k++;
    end while (rd_q[b] !== v && k < 400);
    chkb("status poll", v, rd_q[b]);
  endtask
  task run(input logic [31:0] s, input logic [31:0] d, input logic [31:0] n,
           input logic [31:0] ctl);
    ahb(1, `MCC_STAT, 32'hf);
    ahb(1, `MCC_SRC, s);
    ahb(1, `MCC_DST, d);
    ahb(1, `MCC_XCNT, n);
    ahb(1, `MCC_XMOD, (ctl == 32'h1) ? 32'hfffffffc : 32'h4);
    ahb(1, `MCC_CTRL, ctl);
  endtask
  function automatic logic [31:0] crc4(input logic [31:0] p, input logic rev);
    logic [31:0] r;
    r = 32'hffffffff;
    for (int w = 0; w < 4; w++)
      for (int i = 31; i >= 0; i--)
        r = (r[31] ^ mem_u.mem[w][rev ? 31 - i : i]) ? ((r << 1) ^ p) : (r << 1);
    return r;
  endfunction
  task print_verdict;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    hresetn = 1'b0;
    hsel = 1'b1;
    hwrite = 1'b0;
    htrans = 2'b00;
    haddr = 32'h0;
    hwdata = 32'h0;
    lat = 4'h0;
    for (int i = 0; i < 256; i++) mem_u.mem[i] = 32'hc0de0000 + i;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    foreach (rows[i]) begin
      if (rows[i].w) ahb(1, rows[i].a, rows[i].d);
      ahb(0, rows[i].a, 0);
      chk("register row", rows[i].e, rd_q);
    end
    chkb("irq idle", 0, irq);
    // Stop-mode copy walking downwards
    run(32'h10c, 32'h20c, 32'h4, 32'h1);
    poll(0, 1);
    for (int i = 0; i < 4; i++) chk("down copy", 32'hc0de0040 + i, mem_u.mem[8'h80 + i]);
    chkb("irq raised", 1, irq);
    ahb(1, `MCC_MASK, 32'h0);
    @(posedge hclk);
    chkb("irq masked", 0, irq);
    ahb(1, `MCC_MASK, 32'hf);
    ahb(1, `MCC_STAT, 32'hf);
    @(posedge hclk);
    chkb("irq cleared", 0, irq);
    // Scan, mismatching transfer, other polynomial
    c = crc4(`MCC_POLY_RST, 0);
    w0 = mem_u.wr_cnt;
    ahb(1, `MCC_CEXP, c);
    run(32'h0, 32'h200, 32'h4, 32'h41);
    poll(0, 1);
    ahb(0, `MCC_CRES, 0);
    chk("scan sig", c, rd_q);
    chk("scan writes", w0, mem_u.wr_cnt);
    chk("scan faults", 0, faults);
    ahb(1, `MCC_CEXP, c ^ 32'h1);
    run(32'h0, 32'h200, 32'h4, 32'h81);
    poll(0, 1);
    chk("mismatch faults", 1, faults);
    for (int i = 0; i < 4; i++) chk("xfer data", 32'hc0de0000 + i, mem_u.mem[8'h80 + i]);
    ahb(0, `MCC_STAT, 0);
    chkb("err sticky", 1, rd_q[3]);
    ahb(1, `MCC_STAT, 32'hf);
    ahb(0, `MCC_STAT, 0);
    chkb("err cleared", 0, rd_q[3]);
    // Channel without checker ignores a wrong signature
    ahb(1, `MCC_CHSEL, 32'h5);
    run(32'h0, 32'h200, 32'h4, 32'h41);
    poll(0, 1);
    chk("chsel faults", 1, faults);
    ahb(1, `MCC_CHSEL, 32'h0);
    ahb(1, `MCC_POLY, 32'h1edc6f41);
    c = crc4(32'h1edc6f41, 0);
    ahb(1, `MCC_CEXP, c);
    run(32'h0, 32'h200, 32'h4, 32'h41);
    poll(0, 1);
    ahb(0, `MCC_CRES, 0);
    chk("poly sig", c, rd_q);
    ahb(1, `MCC_POLY, `MCC_POLY_RST);
    // Bit and byte mirroring together reverse each word
    c = crc4(`MCC_POLY_RST, 1);
    ahb(1, `MCC_CEXP, c);
    run(32'h0, 32'h200, 32'h4, 32'h341);
    poll(0, 1);
    ahb(0, `MCC_CRES, 0);
    chk("mirror sig", c, rd_q);
    // Constant fill
    ahb(1, `MCC_FILL, 32'h5a5a1234);
    run(32'h0, 32'h280, 32'h3, 32'hc1);
    poll(0, 1);
    for (int i = 0; i < 4; i++) chk("fill", (i < 3) ? 32'h5a5a1234 : 32'hc0de00a3,
      mem_u.mem[8'ha0 + i]);
    // Four-word descriptor chain on slow memory
    lat <= 4'h3;
    mem_u.mem[8'hc0] = 32'h310; mem_u.mem[8'hc1] = 32'h0;
    mem_u.mem[8'hc2] = 32'h2; mem_u.mem[8'hc3] = 32'hd;
    mem_u.mem[8'hc4] = 32'h300; mem_u.mem[8'hc5] = 32'h10;
    mem_u.mem[8'hc6] = 32'h3; mem_u.mem[8'hc7] = 32'h9;
    mem_u.rd_log.delete();
    w0 = mem_u.wr_cnt;
    ahb(1, `MCC_DPTR, 32'h300);
    run(32'h0, 32'h380, 32'h1, 32'hd);
    poll(0, 1);
    poll(4, 0);
    for (int i = 0; i < 4; i++) chk("desc fetch", 32'h300 + 4 * i, mem_u.rd_log[i]);
    chk("desc src", 32'h0, mem_u.rd_log[4]);
    chk("desc chain", 32'h310, mem_u.rd_log[6]);
    chk("desc writes", w0 + 5, mem_u.wr_cnt);
    // Two rows of two, row stride skips one word
    ahb(1, `MCC_YCNT, 32'h2);
    ahb(1, `MCC_YMOD, 32'h8);
    run(32'h40, 32'h340, 32'h2, 32'h21);
    poll(0, 1);
    for (int i = 0; i < 5; i++) chk("2d copy", (i == 2) ? 32'hc0de00d2 : 32'hc0de0010 + i,
      mem_u.mem[8'hd0 + i]);
    // Circular buffer, then abort
    mem_u.rd_log.delete();
    run(32'h40, 32'h3c0, 32'h4, 32'h3);
    poll(2, 1);
    chkb("half flag", 1, rd_q[1]);
    ahb(1, `MCC_CTRL, 32'h0);
    poll(4, 0);
    chk("wrap start", 32'h40, mem_u.rd_log[4]);
    // Reset after the abort, with the engine idle
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(0, `MCC_MASK, 0);
    chk("mask after reset", 0, rd_q);
    print_verdict;
  end
endmodule

// [mcc_mem_model.sv]
// Behavioural word memory answering the engine's memory port
`timescale 1ns/1ns
module mcc_mem_model (
  input  wire         hclk,
  input  wire         hresetn,
  input  wire [3:0]   lat,
  input  wire         mem_req,
  input  wire         mem_write,
  input  wire [31:0]  mem_addr,
  input  wire [31:0]  mem_wdata,
  output logic [31:0] mem_rdata,
  output logic        mem_ack
);
  logic [31:0] mem [0:255];
  logic [31:0] rd_log [$];
  int          wr_cnt;
  logic [3:0]  cnt;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem_ack <= 1'b0;
      cnt <= 4'h0;
      mem_rdata <= 32'h0;
    end else begin
      // Read data is garbage outside the answer cycle
      mem_rdata <= ~mem_rdata;
      mem_ack <= 1'b0;
      if (mem_req && !mem_ack) begin
        if (cnt >= lat) begin
          cnt <= 4'h0;
          mem_ack <= 1'b1;
          if (mem_write) begin
            mem[mem_addr[9:2]] <= mem_wdata;
            wr_cnt++;
          end else begin
            mem_rdata <= mem[mem_addr[9:2]];
            rd_log.push_back(mem_addr);
          end
        end else begin
          cnt <= cnt + 4'h1;
        end
      end
    end
  end
endmodule

// [mcc_regs.vh]
// Register map, field layout and constants of the memory-copy DMA engine
`ifndef MCC_REGS_VH
`define MCC_REGS_VH

// ------------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------------
`define MCC_CTRL      8'h00
`define MCC_SRC       8'h04
`define MCC_DST       8'h08
`define MCC_XCNT      8'h0c
`define MCC_XMOD      8'h10
`define MCC_YCNT      8'h14
`define MCC_YMOD      8'h18
`define MCC_DPTR      8'h1c
`define MCC_POLY      8'h20
`define MCC_CEXP      8'h24
`define MCC_CRES      8'h28
`define MCC_FILL      8'h2c
`define MCC_STAT      8'h30
`define MCC_MASK      8'h34
`define MCC_CUR       8'h38
`define MCC_CHSEL     8'h3c

// ------------------------------------------------------------------
// Control fields
// ------------------------------------------------------------------
`define MCC_EN        0
`define MCC_FLOW      2:1
`define MCC_KIND      4:3
`define MCC_TWOD      5
`define MCC_CRCM      7:6
`define MCC_BITMIR    8
`define MCC_BYTEMIR   9
`define MCC_FLOW_STOP 2'h0
`define MCC_FLOW_AUTO 2'h1
`define MCC_FLOW_DESC 2'h2
`define MCC_KIND_RING 2'h0
`define MCC_KIND_L4   2'h1
`define MCC_KIND_ARR  2'h2
`define MCC_KIND_L8   2'h3
`define MCC_CRC_OFF   2'h0
`define MCC_CRC_SCAN  2'h1
`define MCC_CRC_XFER  2'h2
`define MCC_CRC_FILL  2'h3

// ------------------------------------------------------------------
// Status bits and reset values
// ------------------------------------------------------------------
`define MCC_ST_DONE   0
`define MCC_ST_HALF   1
`define MCC_ST_WRAP   2
`define MCC_ST_CRCERR 3
`define MCC_CHANNELS  8
`define MCC_CRC_CHANS 3'h4
`define MCC_CRC_INIT  32'hffffffff
`define MCC_POLY_RST  32'h04c11db7

`endif
